// *** touch_cfg_pkg.sv ***
// How it works
// - Pre-measure bit adds one leading sequence
// - Random bit feeds LFSR into period 1
// - Majority field selects 1,3,5..15 sequences
// - Fixed-length bit removes period 1 variation
// - Trigger field picks software, timer, pin
// - Period 1 lasts field plus one cycles
// - Period 1: A,B released, C driven high
// - Period 1 field resets to three
// - Skip bit gives period 2 zero cycles
// - Period 2 lasts field plus one, reset one
// - Period 2 field unused while skipping
// - Period 2: A driven low, B,C released
// - Period 3 lasts field plus one, reset zero
// - Period 3: A,B driven low, C released
// - Timing B upper two bits read zero
// - Count source undivided, halved or quartered
// - Finish clears start bit in software trigger mode only
package touch_cfg_pkg;

  localparam int ADDR_W = 12;

  // Register indexes; byte address is four times the index
  localparam logic [9:0] CTRL_IDX = 10'h2C0;
  localparam logic [9:0] MODE_IDX = 10'h2C1;
  localparam logic [9:0] TA_IDX   = 10'h2C2;
  localparam logic [9:0] TB_IDX   = 10'h2C3;
  localparam logic [9:0] STAT_IDX = 10'h2E0;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] TA_RST   = 8'h03;
  localparam logic [7:0] TB_RST   = 8'h01;
  localparam logic [7:0] TB_MASK  = 8'h3F;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CSRC_LSB  = 4;
  localparam int MODE_PRE_BIT   = 0;
  localparam int MODE_RAND_BIT  = 1;
  localparam int MODE_MAJ_LSB   = 2;
  localparam int MODE_CONST_BIT = 5;
  localparam int MODE_TRIG_LSB  = 6;
  localparam int TA_P1_LSB      = 0;
  localparam int TA_SKIP_BIT    = 7;
  localparam int TB_P2_LSB      = 0;
  localparam int TB_P3_LSB      = 4;

  localparam logic [1:0] TRIG_SW    = 2'b00;
  localparam logic [1:0] TRIG_TIMER = 2'b10;
  localparam logic [1:0] TRIG_EXT   = 2'b11;

  localparam logic [1:0] CSRC_F1 = 2'b00;
  localparam logic [1:0] CSRC_F2 = 2'b01;

  localparam logic [7:0] LFSR_SEED = 8'hA5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_P1   = 3'b001,
    ST_P2   = 3'b010,
    ST_P3   = 3'b011
  } seq_state_t;

endpackage

// *** period_count.sv ***
`timescale 1ns/1ps
`default_nettype none
module period_count
  import touch_cfg_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic              zero
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Load wins; otherwise count down on each source tick
  assign cnt_d = load ? load_val :
                 (tick && cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
  assign zero  = (cnt_q == '0);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// *** touch_sensor_measure_timing_cfg.sv ***
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_measure_timing_cfg
  import touch_cfg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              timer_trig,
  input  wire logic              ext_trigger_pin,
  output logic                   sense_pin_a_out,
  output logic                   sense_pin_a_oe,
  output logic                   sense_pin_b_out,
  output logic                   sense_pin_b_oe,
  output logic                   sense_pin_c_out,
  output logic                   sense_pin_c_oe,
  output logic                   meas_done,
  output logic                   busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0]       ctrl_q;
  logic [7:0]       ctrl_d;
  logic [7:0]       mode_q;
  logic [7:0]       mode_d;
  logic [7:0]       ta_q;
  logic [7:0]       ta_d;
  logic [7:0]       tb_q;
  logic [7:0]       tb_d;
  seq_state_t       state_q;
  seq_state_t       state_d;
  logic [4:0]       meas_q;
  logic [4:0]       meas_d;
  logic [7:0]       lfsr_q;
  logic [7:0]       lfsr_d;
  logic [1:0]       div_q;
  logic             ext_s1_q;
  logic             ext_s2_q;
  logic             ext_s3_q;
  logic             timer_q;
  logic             done_q;
  logic [2:0]       pin_oe_q;
  logic [2:0]       pin_out_q;
  logic [2:0]       pin_oe_d;
  logic [2:0]       pin_out_d;
  logic [31:0]      rd_val;
  logic [31:0]      prdata_q;
  logic [31:0]      prdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire        acc      = psel && penable;
  wire        wr_en    = acc && pwrite;
  wire        word_ok  = (paddr[1:0] == 2'b00);
  wire [9:0]  idx      = paddr[ADDR_W-1:2];
  wire        hit_ctrl = word_ok && idx == CTRL_IDX;
  wire        hit_mode = word_ok && idx == MODE_IDX;
  wire        hit_ta   = word_ok && idx == TA_IDX;
  wire        hit_tb   = word_ok && idx == TB_IDX;
  wire        hit_stat = word_ok && idx == STAT_IDX;
  wire        mapped   = hit_ctrl | hit_mode | hit_ta | hit_tb | hit_stat;
  wire        wr_ctrl  = wr_en && hit_ctrl;

  wire [7:0]  stat_val = {busy, 2'b00, meas_q};

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Read data captured in setup, stands through the access phase
  assign prdata_d = (psel && !penable) ? rd_val : prdata_q;
  assign prdata   = prdata_q;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_val[7:0] = ctrl_q;
    end else if (hit_mode) begin
      rd_val[7:0] = mode_q;
    end else if (hit_ta) begin
      rd_val[7:0] = ta_q;
    end else if (hit_tb) begin
      rd_val[7:0] = tb_q & TB_MASK;
    end else if (hit_stat) begin
      rd_val[7:0] = stat_val;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field views

  wire       soft_start_bit = ctrl_q[CTRL_START_BIT];
  wire [1:0] count_src_sel  = ctrl_q[CTRL_CSRC_LSB +: 2];
  wire       pre_measure_en = mode_q[MODE_PRE_BIT];
  wire       random_en      = mode_q[MODE_RAND_BIT];
  wire [2:0] majority_sel   = mode_q[MODE_MAJ_LSB +: 3];
  wire       fixed_len      = mode_q[MODE_CONST_BIT];
  wire [1:0] trigger_src    = mode_q[MODE_TRIG_LSB +: 2];
  wire [6:0] period1_len    = ta_q[TA_P1_LSB +: 7];
  wire       period2_skip   = ta_q[TA_SKIP_BIT];
  wire [3:0] period2_len    = tb_q[TB_P2_LSB +: 4];
  wire [1:0] period3_len    = tb_q[TB_P3_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Count source ticks

  wire tick_src = (count_src_sel == CSRC_F1) ? 1'b1 :
                  (count_src_sel == CSRC_F2) ? div_q[0] :
                  (div_q == 2'b11);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger selection

  wire sw_mode   = (trigger_src == TRIG_SW);
  wire hw_mode   = (trigger_src == TRIG_TIMER) || (trigger_src == TRIG_EXT);
  wire ext_rise  = ext_s2_q && !ext_s3_q;
  wire tmr_rise  = timer_trig && !timer_q;
  wire hw_evt    = (trigger_src == TRIG_TIMER) ? tmr_rise :
                   (trigger_src == TRIG_EXT)   ? ext_rise :
                   1'b0;
  wire start_go  = (state_q == ST_IDLE) && soft_start_bit &&
                   (sw_mode || hw_evt);
  wire running   = (state_q != ST_IDLE) && soft_start_bit;
  wire hw_abort  = (state_q != ST_IDLE) && !soft_start_bit && hw_mode;
  wire tick      = running && tick_src;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence lengths

  wire [4:0] last_meas = ((majority_sel == 3'b000) ? 5'd0 :
                          {1'b0, majority_sel, 1'b0}) +
                         {4'd0, pre_measure_en};
  wire [2:0] rand_add  = random_en ? lfsr_q[2:0] : 3'd0;
  wire [3:0] var_add   = fixed_len ? 4'd0 :
                         ({1'b0, rand_add} + {2'b00, meas_q[1:0]});
  wire [7:0] p1_load   = {1'b0, period1_len} + {4'd0, var_add};
  wire [7:0] p2_load   = {4'd0, period2_len};
  wire [7:0] p3_load   = {6'd0, period3_len};
  wire       cnt_zero;
  wire       adv       = tick && cnt_zero;
  wire       seq_end   = adv && (state_q == ST_P3);
  wire       last_end  = seq_end && (meas_q == last_meas);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic       load;
  logic [7:0] load_val;

  always_comb begin
    state_d  = state_q;
    meas_d   = meas_q;
    load     = 1'b0;
    load_val = p1_load;
    if (hw_abort) begin
      state_d = ST_IDLE;
      meas_d  = 5'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_go) begin
            state_d = ST_P1;
            meas_d  = 5'd0;
            load    = 1'b1;
          end
        end
        ST_P1: begin
          if (adv) begin
            load = 1'b1;
            if (period2_skip) begin
              state_d  = ST_P3;
              load_val = p3_load;
            end else begin
              state_d  = ST_P2;
              load_val = p2_load;
            end
          end
        end
        ST_P2: begin
          if (adv) begin
            state_d  = ST_P3;
            load     = 1'b1;
            load_val = p3_load;
          end
        end
        ST_P3: begin
          if (last_end) begin
            state_d = ST_IDLE;
            meas_d  = 5'd0;
          end else if (seq_end) begin
            state_d = ST_P1;
            meas_d  = meas_q + 5'd1;
            load    = 1'b1;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  period_count #(
    .W (8)
  ) u_period_count (
    .clk      (clk),
    .nrst     (nrst),
    .load     (load),
    .load_val (load_val),
    .tick     (tick),
    .zero     (cnt_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive per period

  always_comb begin
    pin_oe_d  = 3'b000;
    pin_out_d = 3'b000;
    case (state_d)
      ST_P1: begin
        pin_oe_d  = 3'b100;
        pin_out_d = 3'b100;
      end
      ST_P2: begin
        pin_oe_d  = 3'b001;
      end
      ST_P3: begin
        pin_oe_d  = 3'b011;
      end
      default: begin
        pin_oe_d  = 3'b000;
      end
    endcase
  end

  assign sense_pin_a_oe  = pin_oe_q[0];
  assign sense_pin_b_oe  = pin_oe_q[1];
  assign sense_pin_c_oe  = pin_oe_q[2];
  assign sense_pin_a_out = pin_out_q[0];
  assign sense_pin_b_out = pin_out_q[1];
  assign sense_pin_c_out = pin_out_q[2];
  assign meas_done       = done_q;
  assign busy            = (state_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Register next values

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = pwdata[7:0];
    end else if (last_end && sw_mode) begin
      ctrl_d[CTRL_START_BIT] = 1'b0;
    end
  end

  assign mode_d = (wr_en && hit_mode) ? pwdata[7:0] : mode_q;
  assign ta_d   = (wr_en && hit_ta) ? pwdata[7:0] : ta_q;
  assign tb_d   = (wr_en && hit_tb) ? (pwdata[7:0] & TB_MASK) : tb_q;
  assign lfsr_d = (load && load_val == p1_load && state_d == ST_P1) ?
                  {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]} :
                  lfsr_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      mode_q <= MODE_RST;
      ta_q   <= TA_RST;
      tb_q   <= TB_RST;
    end else begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      ta_q   <= ta_d;
      tb_q   <= tb_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q   <= ST_IDLE;
      meas_q    <= 5'd0;
      lfsr_q    <= LFSR_SEED;
      done_q    <= 1'b0;
      pin_oe_q  <= 3'b000;
      pin_out_q <= 3'b000;
    end else begin
      state_q   <= state_d;
      meas_q    <= meas_d;
      lfsr_q    <= lfsr_d;
      done_q    <= last_end;
      pin_oe_q  <= pin_oe_d;
      pin_out_q <= pin_out_d;
    end
  end

  // Prescaler and trigger synchroniser
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q    <= 2'b00;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      timer_q  <= 1'b0;
    end else begin
      div_q    <= div_q + 2'b01;
      ext_s1_q <= ext_trigger_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      timer_q  <= timer_trig;
    end
  end

endmodule
`default_nettype wire

// *** touch_sensor_measure_timing_cfg_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module touch_cfg_checker
  import touch_cfg_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              sense_pin_a_out,
  input wire logic              sense_pin_a_oe,
  input wire logic              sense_pin_b_out,
  input wire logic              sense_pin_b_oe,
  input wire logic              sense_pin_c_out,
  input wire logic              sense_pin_c_oe,
  input wire logic              meas_done,
  input wire logic              busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic acc    = psel && penable;
  wire logic hit    = paddr[11:2] inside {CTRL_IDX, MODE_IDX, TA_IDX, TB_IDX, STAT_IDX};
  wire logic mapped = hit && (paddr[1:0] == 2'b00);
  ////////////////////////////////////////////////////////////////
  sequence s_p1_leave;
    sense_pin_c_oe ##1 (!sense_pin_c_oe && busy);
  endsequence
  ////////////////////////////////////////////////////////////////
  a_p1_drive: assert property (sense_pin_c_oe |-> sense_pin_c_out && !sense_pin_a_oe
    && !sense_pin_b_oe) else $error("period 1 pin state");
  a_p2_drive: assert property (sense_pin_a_oe && !sense_pin_b_oe |-> !sense_pin_a_out
    && !sense_pin_c_oe) else $error("period 2 pin state");
  a_p3_drive: assert property (sense_pin_b_oe |-> sense_pin_a_oe && !sense_pin_a_out
    && !sense_pin_b_out && !sense_pin_c_oe) else $error("period 3 pin state");
  a_start_p1: assert property ($rose(busy) |-> sense_pin_c_oe)
    else $error("run not started in period 1");
  a_p1_next: assert property (s_p1_leave |-> sense_pin_a_oe)
    else $error("period 1 not followed");
  a_p1_len: assert property ($rose(sense_pin_c_oe) |-> ##[1:1000] !sense_pin_c_oe)
    else $error("period 1 too long");
  a_p2_len: assert property ($rose(sense_pin_a_oe) && !sense_pin_b_oe |-> ##[1:64]
    sense_pin_b_oe) else $error("period 2 too long");
  a_p3_len: assert property ($rose(sense_pin_b_oe) |-> ##[1:16] !sense_pin_b_oe)
    else $error("period 3 too long");
  a_idle_float: assert property (!busy |-> !(sense_pin_a_oe || sense_pin_b_oe
    || sense_pin_c_oe)) else $error("pin driven while idle");
  a_done_once: assert property (meas_done |-> !busy ##1 !meas_done)
    else $error("done pulse wrong");
  a_tb_upper: assert property (acc && paddr == {TB_IDX, 2'b00} |-> prdata[31:6] == '0)
    else $error("timing b upper bits set");
  a_unmapped: assert property (acc && !mapped |-> pslverr && prdata == '0)
    else $error("unmapped access accepted");
endmodule
bind touch_sensor_measure_timing_cfg touch_cfg_checker touch_cfg_checker_inst (.clk,
  .nrst, .psel, .penable, .paddr, .prdata, .pslverr, .sense_pin_a_out, .sense_pin_a_oe,
  .sense_pin_b_out, .sense_pin_b_oe, .sense_pin_c_out, .sense_pin_c_oe, .meas_done, .busy);
`default_nettype wire

// *** touch_electrode_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module touch_electrode_model (
  input wire logic       clk,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  output logic [2:0]     pad_level
);
  logic [2:0] last_q = 3'h0;
  // Floating electrode wanders every cycle
  assign pad_level = (pin_oe & pin_out) | (~pin_oe & ~last_q);
  always_ff @(posedge clk) last_q <= pad_level;
endmodule
`default_nettype wire

// *** touch_sensor_measure_timing_cfg_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_measure_timing_cfg_tb
  import touch_cfg_pkg::*;
;
  localparam logic [11:0] a_ctrl = {CTRL_IDX, 2'b00};
  localparam logic [11:0] a_mode = {MODE_IDX, 2'b00};
  localparam logic [11:0] a_ta   = {TA_IDX, 2'b00};
  localparam logic [11:0] a_tb   = {TB_IDX, 2'b00};
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic        timer_trig = 0, ext_trigger_pin = 0, re;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic        pready, pslverr, a_out, a_oe, b_out, b_oe, c_out, c_oe, meas_done, busy;
  logic [2:0]  pads;
  int          fails = 0, total_checks = 0, p1, p2, p3, ns, q;
  always #5 clk = ~clk;
  touch_sensor_measure_timing_cfg touch_sensor_measure_timing_cfg_inst (.clk(clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_trig(timer_trig), .ext_trigger_pin(ext_trigger_pin), .sense_pin_a_out(a_out),
    .sense_pin_a_oe(a_oe), .sense_pin_b_out(b_out), .sense_pin_b_oe(b_oe),
    .sense_pin_c_out(c_out), .sense_pin_c_oe(c_oe), .meas_done(meas_done), .busy(busy));
  touch_electrode_model touch_electrode_model_inst (.clk(clk), .pin_out({c_out, b_out, a_out}),
    .pin_oe({c_oe, b_oe, a_oe}), .pad_level(pads));
  ////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      results;
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rv, e);
  endtask
  // Start by control write, optional trigger pulse, count period cycles
  task meas(input logic [7:0] ctl, input logic [1:0] trg);
    int  n;
    logic pc;
    n = 0;
    pc = 1'b0;
    {p1, p2, p3, ns} = '0;
    apb(1'b1, a_ctrl, ctl);
    while (meas_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
      if (n == 1) begin
        timer_trig <= trg[0];
        ext_trigger_pin <= trg[1];
      end
      if (n == 2) timer_trig <= 1'b0;
      if (n == 2) chk(busy, {31'h0, trg == 2'b00});
      if (n == 5) ext_trigger_pin <= 1'b0;
      if (c_oe === 1'b1 && pc !== 1'b1) ns++;
      pc = c_oe;
      if (c_oe === 1'b1) p1++;
      if (a_oe === 1'b1 && b_oe !== 1'b1) p2++;
      if (b_oe === 1'b1) p3++;
      if (c_oe === 1'b1) chk(pads[2], 32'h1);
      if (a_oe === 1'b1) chk(pads[0], 32'h0);
      if (b_oe === 1'b1) chk(pads[1], 32'h0);
    end
    if (n >= 3000) begin
      fails++;
      results;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(a_ctrl, 32'h00);
    rdc(a_mode, 32'h00);
    rdc(a_ta, 32'h03);
    rdc(a_tb, 32'h01);
    rdc(12'hB80, 32'h00);
    apb(1'b0, 12'hB10, 8'h00);
    chk(re, 32'h1);
    $display("test reset finished");
  endtask
  task t_walk;
    apb(1'b1, a_mode, 8'h20);
    meas(8'h01, 2'b00);
    chk(p1, 32'd4);
    chk(p2, 32'd2);
    chk(p3, 32'd1);
    chk(ns, 32'd1);
    rdc(a_ctrl, 32'h00);
    $display("test walk finished");
  endtask
  task t_bounds;
    apb(1'b1, a_ta, 8'h7F);
    apb(1'b1, a_tb, 8'hFF);
    rdc(a_tb, 32'h3F);
    meas(8'h01, 2'b00);
    chk(p1, 32'd128);
    chk(p2, 32'd16);
    chk(p3, 32'd4);
    apb(1'b1, a_ta, 8'h80);
    meas(8'h01, 2'b00);
    chk(p1, 32'd1);
    chk(p2, 32'd0);
    $display("test bounds finished");
  endtask
  task t_major;
    for (int m = 0; m < 8; m++) begin
      q = (m == 0 ? 1 : 2 * m + 1) + m % 2;
      apb(1'b1, a_mode, {2'b00, 1'b1, 3'(m), 1'b0, 1'(m % 2)});
      meas(8'h01, 2'b00);
      chk(ns, q);
      chk(p1, q);
    end
    $display("test majority finished");
  endtask
  task t_csrc;
    apb(1'b1, a_mode, 8'h20);
    for (int cs = 0; cs < 3; cs++) begin
      meas({2'b00, 2'(cs), 4'h1}, 2'b00);
      chk(p3, 32'd4 << cs);
    end
    $display("test count source finished");
  endtask
  task t_random;
    apb(1'b1, a_ta, 8'h00);
    apb(1'b1, a_mode, 8'h24);
    meas(8'h01, 2'b00);
    chk(p1, 32'd3);
    apb(1'b1, a_mode, 8'h04);
    meas(8'h01, 2'b00);
    q = p1;
    chk(q > 3, 32'h1);
    apb(1'b1, a_mode, 8'h06);
    meas(8'h01, 2'b00);
    chk(p1 > q, 32'h1);
    $display("test random finished");
  endtask
  task t_trig;
    apb(1'b1, a_mode, 8'hA0);
    meas(8'h01, 2'b01);
    chk(ns, 32'd1);
    rdc(a_ctrl, 32'h01);
    apb(1'b1, a_mode, 8'hE0);
    meas(8'h01, 2'b10);
    chk(ns, 32'd1);
    apb(1'b1, a_ctrl, 8'h00);
    $display("test triggers finished");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_walk;
    t_bounds;
    t_major;
    t_csrc;
    t_random;
    t_trig;
    results;
  end
endmodule
`default_nettype wire
